/* File: wa_req_defines.svh */
/*
  Offsets, field positions, request codes and reset values for the
  wire adapter request decoder. Assumes inclusion by bare name.
*/
`ifndef WA_REQ_DEFINES_SVH
`define WA_REQ_DEFINES_SVH
`define OFF_PIPE_CAPS 8'h18
`define OFF_PIPE_RETRY 8'h19
`define OFF_PIPE_ERR_LO 8'h1A
`define OFF_PIPE_ERR_HI 8'h1B
`define CAPS_RESET 8'h0F
`define CAPS_MASK 8'h0F
`define RETRY_RESET 8'h00
`define RETRY_MASK 8'h8F
`define RETRY_LIMIT_MSB 3
`define RETRY_LOW_POWER_BIT 7
`define ERR_COUNT_RESET 16'h0000
`define REQTYPE_OUT 8'h21
`define REQTYPE_IN 8'hA1
`define REQ_ADD_IE 8'h14
`define REQ_DROP_IE 8'h15
`define REQ_SLOTS 8'h16
`define REQ_CLUSTER 8'h17
`define REQ_DEV_INFO 8'h18
`define REQ_GET_TIME 8'h19
`define REQ_STREAM 8'h1A
`define REQ_SLOT_MAP 8'h1B
`define REQ_CH_HALT 8'h1C
`define TIME_SEL_ADJUST 16'h0000
`define TIME_SEL_BEACON_START 16'h0001
`define TIME_SEL_CURRENT 16'h0002
`define LEN_ADJUST 16'h0001
`define LEN_TIME 16'h0003
`define LEN_DEV_INFO 16'h0024
`define LEN_SLOT_MAP 16'h0020
`define LEN_ZERO 16'h0000
`define INFO_ELEMENT_SLOT_COUNT 8'h08
`define INTERVAL_EVERY 8'h00
`define INTERVAL_INFINITE 8'hFF
`endif

/* File: wa_req_pkg.sv */
/*
  Types for the wire adapter request decoder.
  Assumes the constants of wa_req_defines.svh.
*/
`default_nettype none
package wa_req_pkg;
  typedef struct packed {
    logic [7:0] request_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } setup_type;

  typedef enum logic [3:0] {
    KIND_NONE, KIND_ADD_IE, KIND_DROP_IE, KIND_SLOTS, KIND_CLUSTER, KIND_DEV_INFO,
    KIND_GET_TIME, KIND_STREAM, KIND_SLOT_MAP, KIND_CH_HALT
  } req_kind_type;

  typedef enum logic [1:0] {
    IE_EVERY, IE_PERIODIC, IE_FINITE
  } ie_mode_type;

  typedef struct packed {
    ie_mode_type mode;
    logic [7:0] interval;
    logic [7:0] repeat_count;
    logic [7:0] handle;
    logic [7:0] interface_num;
  } ie_cmd_type;
endpackage
`default_nettype wire

/* File: retry_tracker.sv */
/*
  Retry limiting and transaction error counting for one remote pipe.
  Assumes transaction outcome pulses are synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wa_req_defines.svh"
module retry_tracker (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset
  input wire logic i_ce, // clock enable
  input wire logic [7:0] i_retry_opts, // retry options byte
  input wire logic i_txn_err, // transaction ended in error
  input wire logic i_txn_ok, // transaction succeeded
  input wire logic i_cnt_wr_lo, // software writes low count byte
  input wire logic i_cnt_wr_hi, // software writes high count byte
  input wire logic [7:0] i_cnt_wdata, // write byte
  output logic [15:0] o_err_count, // error counter
  output logic o_transfer_fail // transfer failed pulse
);
  logic [3:0] retries;
  logic [3:0] next_retries;
  logic [15:0] next_err_count;
  logic next_fail;
  logic [3:0] limit;
  logic low_power;

  assign limit = i_retry_opts[`RETRY_LIMIT_MSB:0];
  assign low_power = i_retry_opts[`RETRY_LOW_POWER_BIT];

  always_comb begin
    next_retries = retries;
    next_err_count = o_err_count;
    next_fail = 1'b0;
    if (i_cnt_wr_lo) begin
      next_err_count[7:0] = i_cnt_wdata;
    end
    if (i_cnt_wr_hi) begin
      next_err_count[15:8] = i_cnt_wdata;
    end
    // Increment applied after a software write so an error is never lost
    if (i_txn_err && limit != 4'h0 && next_err_count != 16'hFFFF) begin
      next_err_count = next_err_count + 16'h0001;
    end
    if (i_txn_ok) begin
      next_retries = 4'h0;
    end else if (i_txn_err && limit != 4'h0 && !low_power) begin
      if (retries == limit) begin
        next_fail = 1'b1;
        next_retries = 4'h0;
      end else begin
        next_retries = retries + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      retries <= 4'h0;
      o_err_count <= `ERR_COUNT_RESET;
      o_transfer_fail <= 1'b0;
    end else if (i_ce) begin
      retries <= next_retries;
      o_err_count <= next_err_count;
      o_transfer_fail <= next_fail;
    end
  end

  property p_fail_at_limit;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_txn_err && !i_txn_ok && limit != 4'h0 && !low_power && retries == limit |=> o_transfer_fail;
  endproperty
  a_fail_at_limit: assert property (p_fail_at_limit) else $error("transfer not failed at retry limit");

  property p_no_fail_unlimited;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && (limit == 4'h0 || low_power) |=> !o_transfer_fail;
  endproperty
  a_no_fail_unlimited: assert property (p_no_fail_unlimited) else $error("fail without active limit");

  property p_no_count_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && limit == 4'h0 && !i_cnt_wr_lo && !i_cnt_wr_hi |=> $stable(o_err_count);
  endproperty
  a_no_count_zero: assert property (p_no_count_zero) else $error("errors counted with zero limit");

  property p_err_inc;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_txn_err && limit != 4'h0 && !i_cnt_wr_lo && !i_cnt_wr_hi && o_err_count != 16'hFFFF
      |=> o_err_count == $past(o_err_count) + 16'h0001;
  endproperty
  a_err_inc: assert property (p_err_inc) else $error("error counter did not step");
endmodule
`default_nettype wire

/* File: wa_request_decoder.sv */
/*
  Class request decoder and remote pipe descriptor fields of a host wire
  adapter. Assumes the device core delivers each setup packet as a one-cycle
  strobe and moves descriptor bytes over a byte port at descriptor offsets.
*/
// Behaviour
// - Capability byte flags control, isochronous, bulk, interrupt in bits 0-3.
// - Software may rewrite descriptor fields; capability writes are ignored.
// - Transfer fails once a transaction was retried retry_limit times.
// - retry_limit 0-15; zero disables error counting and retry limiting.
// - Low-power interrupt bit 7 makes retry_limit ignored for retry limiting but not for error counting; bits 6:4 reserved.
// - Transaction error counter increments on each downstream transaction error while retry_limit is nonzero, saturating at FFFFh.
// - Decode request codes 20 through 28.
// - Add IE uses type 21h; value interval/repeat, index handle/interface.
// - Get time uses type A1h; selector 0,1,2; one or three bytes returned.
// - Interval 0 every command, 1-254 periodic, 255 only repeat-count times.
// - Add IE with handle above slot count is a request error.
`timescale 1ns/1ps
`default_nettype none
`include "wa_req_defines.svh"
module wa_request_decoder
  import wa_req_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset
  input wire logic i_ce, // clock enable
  input wire logic i_setup_valid, // setup packet strobe
  input wire setup_type i_setup, // setup packet fields
  input wire logic [7:0] i_time_adjust, // beacon adjustment value
  input wire logic [23:0] i_time_beacon, // channel time at beacon start
  input wire logic [23:0] i_time_current, // current channel time
  input wire logic i_desc_wr, // descriptor byte write
  input wire logic [7:0] i_desc_addr, // descriptor byte offset
  input wire logic [7:0] i_desc_wdata, // descriptor write byte
  input wire logic i_txn_err, // downstream transaction error
  input wire logic i_txn_ok, // downstream transaction success
  output logic o_req_ack, // request accepted pulse
  output logic o_req_error, // request error pulse
  output req_kind_type o_req_kind, // decoded request
  output logic [15:0] o_data_len, // expected data stage length
  output logic [23:0] o_resp_data, // get-time answer, low byte first
  output ie_cmd_type o_ie_cmd, // last accepted info element command
  output logic [7:0] o_desc_rdata, // descriptor read byte
  output logic [7:0] o_retry_opts, // retry options byte
  output logic [15:0] o_err_count, // transaction error counter
  output logic o_transfer_fail // transfer failed pulse
);
  // ==========================================================
  // Request decode
  // ==========================================================
  logic next_ack;
  logic next_error;
  req_kind_type next_kind;
  logic [15:0] next_len;
  logic [23:0] next_resp;
  ie_cmd_type next_ie;
  logic [7:0] vhi;
  logic [7:0] ihi;
  logic bad;

  assign vhi = i_setup.value[15:8];
  assign ihi = i_setup.index[15:8];

  always_comb begin
    next_ack = 1'b0;
    next_error = 1'b0;
    next_kind = o_req_kind;
    next_len = o_data_len;
    next_resp = o_resp_data;
    next_ie = o_ie_cmd;
    bad = 1'b0;
    if (i_setup_valid) begin
      next_kind = KIND_NONE;
      next_len = `LEN_ZERO;
      unique case (i_setup.request)
        `REQ_ADD_IE: begin
          next_kind = KIND_ADD_IE;
          bad = i_setup.request_type != `REQTYPE_OUT || ihi > `INFO_ELEMENT_SLOT_COUNT;
          next_len = i_setup.length;
        end
        `REQ_DROP_IE: begin
          next_kind = KIND_DROP_IE;
          bad = i_setup.request_type != `REQTYPE_OUT || i_setup.value != 16'h0000
              || i_setup.length != `LEN_ZERO || ihi > `INFO_ELEMENT_SLOT_COUNT;
        end
        `REQ_SLOTS, `REQ_CLUSTER, `REQ_STREAM, `REQ_CH_HALT: begin
          next_kind = i_setup.request == `REQ_SLOTS ? KIND_SLOTS
                    : i_setup.request == `REQ_CLUSTER ? KIND_CLUSTER
                    : i_setup.request == `REQ_STREAM ? KIND_STREAM : KIND_CH_HALT;
          bad = i_setup.request_type != `REQTYPE_OUT || i_setup.length != `LEN_ZERO;
        end
        `REQ_DEV_INFO: begin
          next_kind = KIND_DEV_INFO;
          next_len = `LEN_DEV_INFO;
          bad = i_setup.request_type != `REQTYPE_OUT || i_setup.length != `LEN_DEV_INFO;
        end
        `REQ_SLOT_MAP: begin
          next_kind = KIND_SLOT_MAP;
          next_len = `LEN_SLOT_MAP;
          bad = i_setup.request_type != `REQTYPE_OUT || i_setup.length != `LEN_SLOT_MAP;
        end
        `REQ_GET_TIME: begin
          next_kind = KIND_GET_TIME;
          bad = i_setup.request_type != `REQTYPE_IN;
          if (i_setup.value == `TIME_SEL_ADJUST) begin
            bad = bad || i_setup.length != `LEN_ADJUST;
            next_len = `LEN_ADJUST;
            next_resp = {16'h0000, i_time_adjust};
          end else if (i_setup.value == `TIME_SEL_BEACON_START) begin
            bad = bad || i_setup.length != `LEN_TIME;
            next_len = `LEN_TIME;
            next_resp = i_time_beacon;
          end else if (i_setup.value == `TIME_SEL_CURRENT) begin
            bad = bad || i_setup.length != `LEN_TIME;
            next_len = `LEN_TIME;
            next_resp = i_time_current;
          end else begin
            bad = 1'b1;
          end
        end
        default: begin
          bad = 1'b1;
        end
      endcase
      next_ack = !bad;
      next_error = bad;
      if (bad) begin
        next_len = `LEN_ZERO;
      end else if (next_kind == KIND_ADD_IE) begin
        next_ie.interval = vhi;
        next_ie.repeat_count = i_setup.value[7:0];
        next_ie.handle = ihi;
        next_ie.interface_num = i_setup.index[7:0];
        // Repeat count is kept but meaningless in every-command mode
        next_ie.mode = vhi == `INTERVAL_EVERY ? IE_EVERY
                     : vhi == `INTERVAL_INFINITE ? IE_FINITE : IE_PERIODIC;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_req_ack <= 1'b0;
      o_req_error <= 1'b0;
      o_req_kind <= KIND_NONE;
      o_data_len <= `LEN_ZERO;
      o_resp_data <= 24'h000000;
      o_ie_cmd <= '0;
    end else if (i_ce) begin
      o_req_ack <= next_ack;
      o_req_error <= next_error;
      o_req_kind <= next_kind;
      o_data_len <= next_len;
      o_resp_data <= next_resp;
      o_ie_cmd <= next_ie;
    end
  end

  // ==========================================================
  // Remote pipe descriptor fields
  // ==========================================================
  logic [7:0] caps;
  logic [7:0] next_caps;
  logic [7:0] next_retry_opts;
  logic [7:0] next_rdata;
  logic wr_lo;
  logic wr_hi;

  assign wr_lo = i_desc_wr && i_desc_addr == `OFF_PIPE_ERR_LO;
  assign wr_hi = i_desc_wr && i_desc_addr == `OFF_PIPE_ERR_HI;

  always_comb begin
    next_caps = `CAPS_RESET & `CAPS_MASK;
    next_retry_opts = o_retry_opts;
    if (i_desc_wr && i_desc_addr == `OFF_PIPE_RETRY) begin
      next_retry_opts = i_desc_wdata & `RETRY_MASK;
    end
    // Reads see the value before a same-cycle write
    unique case (i_desc_addr)
      `OFF_PIPE_CAPS: next_rdata = caps;
      `OFF_PIPE_RETRY: next_rdata = o_retry_opts;
      `OFF_PIPE_ERR_LO: next_rdata = o_err_count[7:0];
      `OFF_PIPE_ERR_HI: next_rdata = o_err_count[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      caps <= `CAPS_RESET;
      o_retry_opts <= `RETRY_RESET;
      o_desc_rdata <= 8'h00;
    end else if (i_ce) begin
      caps <= next_caps;
      o_retry_opts <= next_retry_opts;
      o_desc_rdata <= next_rdata;
    end
  end

  retry_tracker u_retry (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_retry_opts(o_retry_opts),
    .i_txn_err(i_txn_err),
    .i_txn_ok(i_txn_ok),
    .i_cnt_wr_lo(wr_lo),
    .i_cnt_wr_hi(wr_hi),
    .i_cnt_wdata(i_desc_wdata),
    .o_err_count(o_err_count),
    .o_transfer_fail(o_transfer_fail)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_setup(logic [7:0] code);
    i_ce && i_setup_valid && i_setup.request == code;
  endsequence

  property p_caps_ro;
    @(posedge i_clk) disable iff (!i_rst_n) caps == `CAPS_RESET;
  endproperty
  a_caps_ro: assert property (p_caps_ro) else $error("capability byte changed");

  property p_caps_read;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_desc_addr == `OFF_PIPE_CAPS |=> o_desc_rdata == `CAPS_RESET;
  endproperty
  a_caps_read: assert property (p_caps_read) else $error("capability read wrong");

  property p_unknown_code;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_setup_valid && (i_setup.request < `REQ_ADD_IE || i_setup.request > `REQ_CH_HALT)
      |=> o_req_error && !o_req_ack;
  endproperty
  a_unknown_code: assert property (p_unknown_code) else $error("unknown request not refused");

  property p_handle_limit;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_setup(`REQ_ADD_IE) ##0 i_setup.index[15:8] > `INFO_ELEMENT_SLOT_COUNT |=> o_req_error;
  endproperty
  a_handle_limit: assert property (p_handle_limit) else $error("handle above slot count accepted");

  property p_time_len;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_setup(`REQ_GET_TIME) |=> o_req_error || o_data_len == `LEN_ADJUST || o_data_len == `LEN_TIME;
  endproperty
  a_time_len: assert property (p_time_len) else $error("get time length wrong");

  property p_dev_info_len;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_setup(`REQ_DEV_INFO) ##0 i_setup.length != `LEN_DEV_INFO |=> o_req_error;
  endproperty
  a_dev_info_len: assert property (p_dev_info_len) else $error("device info length accepted");

  property p_ie_mode;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_req_ack && o_req_kind == KIND_ADD_IE |-> (o_ie_cmd.interval == `INTERVAL_EVERY) == (o_ie_cmd.mode == IE_EVERY)
      && (o_ie_cmd.interval == `INTERVAL_INFINITE) == (o_ie_cmd.mode == IE_FINITE);
  endproperty
  a_ie_mode: assert property (p_ie_mode) else $error("interval mode wrong");

  property p_add_type;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_setup(`REQ_ADD_IE) ##0 i_setup.request_type != `REQTYPE_OUT |=> !o_req_ack;
  endproperty
  a_add_type: assert property (p_add_type) else $error("add with wrong type accepted");

  property p_retry_reserved;
    @(posedge i_clk) disable iff (!i_rst_n) o_retry_opts[6:4] == 3'h0;
  endproperty
  a_retry_reserved: assert property (p_retry_reserved) else $error("reserved retry bits set");
endmodule
`default_nettype wire

/* File: wa_host_model.sv */
/*
  Host side model: issues setup packets and descriptor byte accesses.
  Assumes i_clk is the decoder's clock; the bench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module wa_host_model
  import wa_req_pkg::*;
(
  input wire logic i_clk, // clock
  output logic o_setup_valid, // setup strobe
  output setup_type o_setup, // setup fields
  output logic o_desc_wr, // descriptor write
  output logic [7:0] o_desc_addr, // descriptor offset
  output logic [7:0] o_desc_wdata // descriptor write byte
);
  initial begin
    o_setup_valid = 1'b0;
    o_setup = '0;
    o_desc_wr = 1'b0;
    o_desc_addr = 8'h00;
    o_desc_wdata = 8'h00;
  end
  // ==========================================
  // Requests
  // Released setup fields and write byte inverted so stale values never pass for a match
  task automatic send_setup(input setup_type s);
    @(posedge i_clk);
    o_setup_valid <= 1'b1;
    o_setup <= s;
    @(posedge i_clk);
    o_setup_valid <= 1'b0;
    o_setup <= ~s;
  endtask
  task automatic desc_access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    o_desc_wr <= wr;
    o_desc_addr <= addr;
    o_desc_wdata <= data;
    @(posedge i_clk);
    o_desc_wr <= 1'b0;
    o_desc_wdata <= ~data;
  endtask
endmodule
`default_nettype wire

/* File: test_wire_adapter_request_decoder.sv */
/*
  Self-checking bench for the request decoder against a behavioural model.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wa_req_defines.svh"
module test_wire_adapter_request_decoder;
  import wa_req_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_txn_err = 1'b0;
  logic i_txn_ok = 1'b0;
  logic [7:0] i_time_adjust = 8'h00;
  logic [23:0] i_time_beacon = 24'h000000;
  logic [23:0] i_time_current = 24'h000000;
  logic setup_valid, desc_wr, o_req_ack, o_req_error, o_transfer_fail;
  setup_type setup;
  logic [7:0] desc_addr, desc_wdata, o_desc_rdata, o_retry_opts;
  req_kind_type o_req_kind;
  logic [15:0] o_data_len, o_err_count;
  logic [23:0] o_resp_data;
  ie_cmd_type o_ie_cmd;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 85659;
  int caps = 8'h0F;
  int retry = 0;
  int cnt = 0;
  int retries = 0;
  int i;
  always #2 i_clk = ~i_clk;
  wa_host_model host (.i_clk(i_clk), .o_setup_valid(setup_valid), .o_setup(setup), .o_desc_wr(desc_wr),
    .o_desc_addr(desc_addr), .o_desc_wdata(desc_wdata));
  wa_request_decoder dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_setup_valid(setup_valid),
    .i_setup(setup), .i_time_adjust(i_time_adjust), .i_time_beacon(i_time_beacon),
    .i_time_current(i_time_current), .i_desc_wr(desc_wr), .i_desc_addr(desc_addr),
    .i_desc_wdata(desc_wdata), .i_txn_err(i_txn_err), .i_txn_ok(i_txn_ok), .o_req_ack(o_req_ack),
    .o_req_error(o_req_error), .o_req_kind(o_req_kind), .o_data_len(o_data_len), .o_resp_data(o_resp_data),
    .o_ie_cmd(o_ie_cmd), .o_desc_rdata(o_desc_rdata), .o_retry_opts(o_retry_opts),
    .o_err_count(o_err_count), .o_transfer_fail(o_transfer_fail));
  // ==========================================
  // Checking
  task automatic complete_run;
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic compare(input string name, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ==========================================
  // Model
  function automatic bit legal(input setup_type s);
    bit out_ok;
    out_ok = (s.request_type == `REQTYPE_OUT);
    case (s.request)
      `REQ_ADD_IE: return out_ok && s.index[15:8] <= `INFO_ELEMENT_SLOT_COUNT;
      `REQ_DROP_IE: return out_ok && s.value == 0 && s.length == 0 && s.index[15:8] <= `INFO_ELEMENT_SLOT_COUNT;
      `REQ_DEV_INFO: return out_ok && s.length == `LEN_DEV_INFO;
      `REQ_SLOT_MAP: return out_ok && s.length == `LEN_SLOT_MAP;
      `REQ_GET_TIME: return s.request_type == `REQTYPE_IN && ((s.value == 0 && s.length == `LEN_ADJUST) ||
        ((s.value == 1 || s.value == 2) && s.length == `LEN_TIME));
      `REQ_SLOTS, `REQ_CLUSTER, `REQ_STREAM, `REQ_CH_HALT: return out_ok && s.length == 0;
      default: return 1'b0;
    endcase
  endfunction
  function automatic setup_type form(input logic [7:0] code, input logic [15:0] val, input logic [15:0] idx);
    setup_type s;
    s.request_type = (code == `REQ_GET_TIME) ? `REQTYPE_IN : `REQTYPE_OUT;
    s.request = code;
    s.value = (code inside {`REQ_DROP_IE, `REQ_DEV_INFO, `REQ_SLOT_MAP}) ? 16'h0000 : val;
    s.index = {idx[15:8] % 8'h09, idx[7:0]};
    s.length = (code == `REQ_DEV_INFO) ? `LEN_DEV_INFO : (code == `REQ_SLOT_MAP) ? `LEN_SLOT_MAP :
      (code == `REQ_ADD_IE) ? 16'h0010 : `LEN_ZERO;
    if (code == `REQ_GET_TIME) begin
      s.value = val % 3;
      s.length = (s.value == 0) ? `LEN_ADJUST : `LEN_TIME;
    end
    return s;
  endfunction
  task automatic request(input setup_type s);
    ie_mode_type m;
    bit ok;
    ok = legal(s);
    @(posedge i_clk);
    i_time_adjust <= $random(seed);
    i_time_beacon <= $random(seed);
    i_time_current <= $random(seed);
    host.send_setup(s);
    #1;
    compare("ack", ok, o_req_ack);
    compare("error", !ok, o_req_error);
    compare("len", ok ? s.length : 16'h0000, o_data_len);
    if (ok) compare("kind", s.request - 8'h13, o_req_kind);
    m = (s.value[15:8] == 8'h00) ? IE_EVERY : (s.value[15:8] == 8'hFF) ? IE_FINITE : IE_PERIODIC;
    if (ok && s.request == `REQ_ADD_IE) compare("ie", {m, s.value, s.index}, o_ie_cmd);
    if (ok && s.request == `REQ_GET_TIME)
      compare("time", s.value == 0 ? {16'h0000, i_time_adjust} : s.value == 1 ? i_time_beacon : i_time_current,
        o_resp_data);
  endtask
  task automatic desc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    host.desc_access(wr, a, d);
    #1;
    if (wr && a == `OFF_PIPE_RETRY) retry = d & `RETRY_MASK;
    if (wr && a == `OFF_PIPE_ERR_LO) cnt[7:0] = d;
    if (wr && a == `OFF_PIPE_ERR_HI) cnt[15:8] = d;
    if (wr) compare("retry", retry, o_retry_opts);
    if (!wr) compare("desc", a == `OFF_PIPE_CAPS ? caps : a == `OFF_PIPE_RETRY ? retry :
      a == `OFF_PIPE_ERR_LO ? cnt[7:0] : a == `OFF_PIPE_ERR_HI ? cnt[15:8] : 0, o_desc_rdata);
  endtask
  task automatic txn(input logic err, input logic ok);
    bit fail;
    @(posedge i_clk);
    i_txn_err <= err;
    i_txn_ok <= ok;
    @(posedge i_clk);
    i_txn_err <= 1'b0;
    i_txn_ok <= 1'b0;
    #1;
    fail = 1'b0;
    if (ok) retries = 0;
    else if (err && retry[3:0] != 0) begin
      if (cnt != 16'hFFFF) cnt++;
      if (!retry[7] && retries == retry[3:0]) begin
        fail = 1'b1;
        retries = 0;
      end else if (!retry[7]) retries++;
    end
    compare("count", cnt, o_err_count);
    compare("fail", fail, o_transfer_fail);
  endtask
  task automatic retry_run(input logic [7:0] opts, input int errs);
    desc(1'b1, `OFF_PIPE_RETRY, opts);
    txn(1'b0, 1'b1);
    repeat (errs) txn(1'b1, 1'b0);
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (i = 8'h17; i <= 8'h1C; i++) desc(1'b0, i[7:0], 8'h00);
    desc(1'b1, `OFF_PIPE_CAPS, 8'hF0);
    desc(1'b0, `OFF_PIPE_CAPS, 8'h00);
    desc(1'b1, `OFF_PIPE_RETRY, 8'hFF);
    desc(1'b0, `OFF_PIPE_RETRY, 8'h00);
    // Write while frozen must be lost
    @(posedge i_clk);
    i_ce <= 1'b0;
    host.desc_access(1'b1, `OFF_PIPE_RETRY, 8'h05);
    #1;
    compare("frozen_retry", retry, o_retry_opts);
    @(posedge i_clk);
    i_ce <= 1'b1;
    for (i = 8'h13; i <= 8'h1D; i++) repeat (3) request(form(i[7:0], $random(seed), $random(seed)));
    request(form(`REQ_ADD_IE, 16'h0003, 16'h0801));
    request('{`REQTYPE_OUT, `REQ_ADD_IE, 16'hFF02, 16'h0901, 16'h0010});
    request(form(`REQ_ADD_IE, 16'hFF02, 16'h0301));
    request(form(`REQ_ADD_IE, 16'h0704, 16'h0000));
    request(form(`REQ_ADD_IE, 16'hFE05, 16'h0000));
    request('{`REQTYPE_OUT, `REQ_DEV_INFO, 16'h0000, 16'h0000, 16'h0023});
    request('{`REQTYPE_OUT, `REQ_DROP_IE, 16'h0000, 16'h0000, 16'h0001});
    request('{`REQTYPE_IN, `REQ_GET_TIME, 16'h0003, 16'h0000, 16'h0003});
    request('{`REQTYPE_OUT, `REQ_GET_TIME, 16'h0001, 16'h0000, 16'h0003});
    for (i = 0; i < 40; i++)
      request('{$random(seed) & 1 ? `REQTYPE_OUT : `REQTYPE_IN, 8'h12 + ($random(seed) & 8'h0F),
        $random(seed) & 16'h0003, $random(seed) & 16'h0F0F, $random(seed) & 16'h0027});
    retry_run(8'h02, 7);
    retry_run(8'h00, 3);
    retry_run(8'h82, 4);
    retry_run(8'h0F, 17);
    desc(1'b1, `OFF_PIPE_ERR_LO, 8'hFF);
    desc(1'b1, `OFF_PIPE_ERR_HI, 8'hFF);
    retry_run(8'h01, 2);
    desc(1'b0, `OFF_PIPE_ERR_HI, 8'h00);
    desc(1'b1, `OFF_PIPE_ERR_LO, 8'h00);
    desc(1'b1, `OFF_PIPE_ERR_HI, 8'h00);
    desc(1'b0, `OFF_PIPE_ERR_LO, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
